//--- verilog/cct_defs.vh
// register map, field layout and reset values of the cascaded timer pair
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH
// byte offsets; unit 0 is the upper byte, unit 1 the lower byte
`define CCT_OFS_COUNT       6'h00
`define CCT_OFS_CLK_CTRL    6'h08
`define CCT_OFS_CONTROL     6'h10
`define CCT_OFS_OUT_CTRL    6'h18
`define CCT_OFS_CMP_A       6'h20
`define CCT_OFS_CMP_B       6'h28
`define CCT_OFS_KEY         6'h30
`define CCT_OFS_MSTOP       6'h34
`define CCT_OFS_STATUS      6'h38
`define CCT_TIMER_TOP       6'h30
// clock control fields
`define CCT_CSS_HI          4
`define CCT_CSS_LO          3
`define CCT_CKS_HI          2
`define CCT_CKS_LO          0
`define CCT_CSS_STOP        2'h0
`define CCT_CSS_PRESCALE    2'h1
`define CCT_CSS_CASCADE     2'h3
// control fields
`define CCT_COUNTER_CLEAR_SELECT_HI         4
`define CCT_COUNTER_CLEAR_SELECT_LO         3
`define CCT_OVF_IE          5
`define CCT_MA_IE           6
`define CCT_MB_IE           7
`define CCT_COUNTER_CLEAR_SELECT_NONE       2'h0
`define CCT_COUNTER_CLEAR_SELECT_MATCH_A    2'h1
`define CCT_COUNTER_CLEAR_SELECT_MATCH_B    2'h2
// output select values
`define CCT_OSA_LOW         2'h1
`define CCT_OSA_HIGH        2'h2
`define CCT_OSA_TOGGLE      2'h3
// write protect key
`define CCT_KEY_CODE        8'hA5
`define CCT_KEY_MSTOP_BIT   1
// reset values and prescaler width
`define CCT_RST_COUNT       8'h00
`define CCT_RST_CMP         8'hFF
`define CCT_RST_CTRL        8'h00
`define CCT_RST_KEY         16'h0000
`define CCT_PSC_W           13
`endif

//--- verilog/cct_timer_unit.v
// one eight-bit timer unit: clock source select and the count register
`timescale 1ns/10ps
`include "cct_defs.vh"
module cct_timer_unit #(
  parameter PSC_W = `CCT_PSC_W
) (
  input  wire             clk_sys,
  input  wire             nrst,
  input  wire             init,
  input  wire             halt,
  input  wire [1:0]       clock_source_select,
  input  wire [2:0]       clock_prescale_select,
  input  wire [PSC_W-1:0] psc,
  input  wire             cascade_tick,
  input  wire             clear,
  input  wire             load,
  input  wire [7:0]       load_data,
  input  wire [7:0]       compare_value_a,
  input  wire [7:0]       compare_value_b,
  output reg  [7:0]       timer_count_value,
  output wire             tick,
  output wire             overflow,
  output wire             eq_a,
  output wire             eq_b
);
  wire [PSC_W-1:0] mask;
  wire             psc_tick;

  // prescaler taps: setting 0 counts every clock, n divides by 2**n
  assign mask     = ~({PSC_W{1'b1}} << clock_prescale_select);
  assign psc_tick = ((psc & mask) == {PSC_W{1'b0}});

  // source select; zero or an unbuilt source leaves the count frozen
  assign tick = halt ? 1'b0 :
    (clock_source_select == `CCT_CSS_PRESCALE) ? psc_tick :
    (clock_source_select == `CCT_CSS_CASCADE) ? cascade_tick :
    1'b0;

  assign overflow = tick && (timer_count_value == 8'hFF);
  assign eq_a     = (timer_count_value == compare_value_a);
  assign eq_b     = (timer_count_value == compare_value_b);

  // software load beats clear, clear beats counting
  always @(posedge clk_sys) begin
    if (!nrst || init) begin
      timer_count_value <= `CCT_RST_COUNT;
    end else if (load) begin
      timer_count_value <= load_data;
    end else if (clear && !halt) begin
      timer_count_value <= `CCT_RST_COUNT;
    end else if (tick) begin
      timer_count_value <= timer_count_value + 8'h01;
    end
  end
endmodule

//--- verilog/cct_timer_pair.v
// cascaded compare toggle timer pair with its wishbone register slave
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`include "cct_defs.vh"
module cct_timer_pair #(
  parameter PSC_W = `CCT_PSC_W
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        low_power_return,
  output reg  [1:0]  timer_output_pin,
  output wire [1:0]  overflow_irq,
  output wire [1:0]  match_a_irq,
  output wire [1:0]  match_b_irq
);
  reg  [7:0]       timer_clock_control [0:1];
  reg  [7:0]       timer_control       [0:1];
  reg  [7:0]       timer_output_control[0:1];
  reg  [7:0]       compare_value_a     [0:1];
  reg  [7:0]       compare_value_b     [0:1];
  reg  [15:0]      write_protect_key;
  reg              timer_pair_stop_bit;
  reg  [PSC_W-1:0] psc;
  reg  [1:0]       match_a_q;
  reg  [1:0]       match_b_q;
  wire [7:0]       count      [0:1];
  wire [1:0]       tick;
  wire [1:0]       ovf;
  wire [1:0]       eq_a;
  wire [1:0]       eq_b;
  wire [1:0]       match_a;
  wire [1:0]       clear;
  wire [1:0]       load;
  wire [1:0]       ev_a;
  wire [1:0]       ev_b;
  wire             cascade;
  wire             pair_clear;
  wire             req;
  wire             wr;
  wire             unit;
  wire             timer_wr;
  reg  [31:0]      next_dat;
  integer          i;

  // bus request in its first cycle; ack is given one clock later
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr       = req && wb_we_i && wb_sel_i[0];
  assign unit     = wb_adr_i[2];
  // a stopped pair has no clock, so its registers take no writes
  assign timer_wr = wr && (wb_adr_i < `CCT_TIMER_TOP)
                    && !timer_pair_stop_bit;

  // cascade is chosen by the upper unit's source select
  assign cascade = (timer_clock_control[0][`CCT_CSS_HI:`CCT_CSS_LO]
                    == `CCT_CSS_CASCADE);
  assign pair_clear = cascade && match_a[0] &&
    (timer_control[0][`CCT_COUNTER_CLEAR_SELECT_HI:`CCT_COUNTER_CLEAR_SELECT_LO] == `CCT_COUNTER_CLEAR_SELECT_MATCH_A);

  // free-running prescaler shared by both units, stopped with the pair
  always @(posedge clk_sys) begin
    if (!nrst || low_power_return) begin
      psc <= {PSC_W{1'b0}};
    end else if (!timer_pair_stop_bit) begin
      psc <= psc + {{(PSC_W-1){1'b0}}, 1'b1};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_unit
      wire [1:0] counter_clear_select;
      wire [1:0] output_select_a;
      assign counter_clear_select = timer_control[g][`CCT_COUNTER_CLEAR_SELECT_HI:`CCT_COUNTER_CLEAR_SELECT_LO];
      assign output_select_a  = timer_output_control[g][1:0];
      // in cascade both units see the 16-bit match
      assign match_a[g] = cascade ? (eq_a[0] && eq_a[1]) : eq_a[g];
      assign clear[g] = cascade ? pair_clear :
        ((counter_clear_select == `CCT_COUNTER_CLEAR_SELECT_MATCH_A) && match_a[g]) ||
        ((counter_clear_select == `CCT_COUNTER_CLEAR_SELECT_MATCH_B) && eq_b[g]);
      assign load[g] = timer_wr && (unit == (g == 1)) &&
                       (wb_adr_i[5:3] == 3'd0);
      // one event per entry into the match state, not per cycle held
      assign ev_a[g] = match_a[g] && !match_a_q[g];
      assign ev_b[g] = eq_b[g] && !match_b_q[g];
      assign overflow_irq[g] = ovf[g] &&
        timer_control[g][`CCT_OVF_IE];
      assign match_a_irq[g] = ev_a[g] && !timer_pair_stop_bit &&
        timer_control[g][`CCT_MA_IE];
      assign match_b_irq[g] = ev_b[g] && !timer_pair_stop_bit &&
        timer_control[g][`CCT_MB_IE];

      cct_timer_unit #(
        .PSC_W (PSC_W)
      ) u_unit (
        .clk_sys               (clk_sys),
        .nrst                  (nrst),
        .init                  (low_power_return),
        .halt                  (timer_pair_stop_bit),
        .clock_source_select   (timer_clock_control[g]
                                [`CCT_CSS_HI:`CCT_CSS_LO]),
        .clock_prescale_select (timer_clock_control[g]
                                [`CCT_CKS_HI:`CCT_CKS_LO]),
        .psc                   (psc),
        .cascade_tick          ((g == 0) ? ovf[1] : 1'b0),
        .clear                 (clear[g]),
        .load                  (load[g]),
        .load_data             (wb_dat_i[7:0]),
        .compare_value_a       (compare_value_a[g]),
        .compare_value_b       (compare_value_b[g]),
        .timer_count_value     (count[g]),
        .tick                  (tick[g]),
        .overflow              (ovf[g]),
        .eq_a                  (eq_a[g]),
        .eq_b                  (eq_b[g])
      );

      // match history and pin action; pin frozen while stopped
      always @(posedge clk_sys) begin
        if (!nrst || low_power_return) begin
          match_a_q[g]        <= 1'b0;
          match_b_q[g]        <= 1'b0;
          timer_output_pin[g] <= 1'b0;
        end else if (!timer_pair_stop_bit) begin
          match_a_q[g] <= match_a[g];
          match_b_q[g] <= eq_b[g];
          if (ev_a[g]) begin
            case (output_select_a)
              `CCT_OSA_LOW:    timer_output_pin[g] <= 1'b0;
              `CCT_OSA_HIGH:   timer_output_pin[g] <= 1'b1;
              `CCT_OSA_TOGGLE: timer_output_pin[g] <= ~timer_output_pin[g];
              default:         timer_output_pin[g] <= timer_output_pin[g];
            endcase
          end
        end
      end
    end
  endgenerate

  // register writes; low-power return puts the timer registers back
  always @(posedge clk_sys) begin
    if (!nrst || low_power_return) begin
      for (i = 0; i < 2; i = i + 1) begin
        timer_clock_control[i]  <= `CCT_RST_CTRL;
        timer_control[i]        <= `CCT_RST_CTRL;
        timer_output_control[i] <= `CCT_RST_CTRL;
        compare_value_a[i]      <= `CCT_RST_CMP;
        compare_value_b[i]      <= `CCT_RST_CMP;
      end
    end else if (timer_wr) begin
      case (wb_adr_i[5:3])
        3'd1: timer_clock_control[unit]  <= wb_dat_i[7:0];
        3'd2: timer_control[unit]        <= wb_dat_i[7:0];
        3'd3: timer_output_control[unit] <= wb_dat_i[7:0];
        3'd4: compare_value_a[unit]      <= wb_dat_i[7:0];
        3'd5: compare_value_b[unit]      <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // key and stop bit live outside the pair and survive low-power return
  always @(posedge clk_sys) begin
    if (!nrst) begin
      write_protect_key   <= `CCT_RST_KEY;
      timer_pair_stop_bit <= 1'b1;
    end else if (wr && wb_adr_i == `CCT_OFS_KEY && wb_sel_i[1] &&
                 wb_dat_i[15:8] == `CCT_KEY_CODE) begin
      write_protect_key <= wb_dat_i[15:0];
    end else if (wr && wb_adr_i == `CCT_OFS_MSTOP &&
                 write_protect_key[`CCT_KEY_MSTOP_BIT]) begin
      timer_pair_stop_bit <= wb_dat_i[0];
    end
  end

  // read mux; unmapped addresses read zero and are still acknowledged
  always @* begin
    next_dat = 32'h0000_0000;
    if (wb_adr_i < `CCT_TIMER_TOP) begin
      case (wb_adr_i[5:3])
        3'd0: next_dat[7:0] = count[unit];
        3'd1: next_dat[7:0] = timer_clock_control[unit];
        3'd2: next_dat[7:0] = timer_control[unit];
        3'd3: next_dat[7:0] = timer_output_control[unit];
        3'd4: next_dat[7:0] = compare_value_a[unit];
        3'd5: next_dat[7:0] = compare_value_b[unit];
        default: next_dat = 32'h0000_0000;
      endcase
    end else if (wb_adr_i == `CCT_OFS_KEY) begin
      next_dat[15:0] = write_protect_key;
    end else if (wb_adr_i == `CCT_OFS_MSTOP) begin
      next_dat[0] = timer_pair_stop_bit;
    end else if (wb_adr_i == `CCT_OFS_STATUS) begin
      next_dat[6:0] = {cascade, match_a, timer_pair_stop_bit,
                       timer_output_pin, 1'b0};
    end
  end

  // single-wait-state slave: ack and data one edge after the request
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= next_dat;
      end
    end
  end
endmodule

//--- sim/cct_timer_pair_monitor.sv
// port checker for the timer pair, bound into its top module
`timescale 1ns/10ps
module cct_pair_checker (
  input wire        clk_sys,
  input wire        nrst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [5:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        low_power_return,
  input wire [1:0]  timer_output_pin,
  input wire [1:0]  overflow_irq,
  input wire [1:0]  match_a_irq,
  input wire [1:0]  match_b_irq
);
  reg  [2:0] ie0;
  reg  [2:0] ie1;
  wire [1:0] ie_ov = {ie1[0], ie0[0]};
  wire [1:0] ie_ma = {ie1[1], ie0[1]};
  wire [1:0] ie_mb = {ie1[2], ie0[2]};
  wire       take  = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire       wr_ok = take & wb_we_i & wb_sel_i[0];
  // enable shadow; assumes control is never written while stopped
  always @(posedge clk_sys) begin
    if (!nrst || low_power_return)
      {ie1, ie0} <= 6'h00;
    else if (wr_ok && wb_adr_i == 6'h10)
      ie0 <= wb_dat_i[7:5];
    else if (wr_ok && wb_adr_i == 6'h14)
      ie1 <= wb_dat_i[7:5];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_answer: assert property (take |=> s_answer)
    else $error("no single ack pulse after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(take))
    else $error("ack without a request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_irq_masked: assert property (((overflow_irq & ~ie_ov) |
    (match_a_irq & ~ie_ma) | (match_b_irq & ~ie_mb)) == 2'h0)
    else $error("interrupt request while disabled");
  a_match_once: assert property (match_a_irq[0] |=> !match_a_irq[0])
    else $error("match event longer than one cycle");
  a_pin_toggle: assert property (disable iff (!nrst || low_power_return)
    match_a_irq[0] |=> timer_output_pin[0] != $past(timer_output_pin[0]))
    else $error("pin did not invert after match");
  a_lp_reinit: assert property (low_power_return |=>
    timer_output_pin == 2'h0 && match_a_irq == 2'h0)
    else $error("low power return left timer state");
  a_reset_idle: assert property ($rose(nrst) |-> !wb_ack_o &&
    timer_output_pin == 2'h0 && wb_dat_o == 32'h0000_0000)
    else $error("outputs not idle after reset");
endmodule
bind cct_timer_pair cct_pair_checker u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .low_power_return(low_power_return),
  .timer_output_pin(timer_output_pin), .overflow_irq(overflow_irq),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq)
);

//--- sim/cct_timer_pair_tb_top.sv
// self-checking bench for the cascaded timer pair
`timescale 1ns/10ps
module cct_timer_pair_tb_top;
  reg         clk_sys = 1'b0;
  reg         nrst = 1'b0;
  reg         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg         low_power_return = 1'b0;
  reg  [5:0]  wb_adr_i = 6'h00;
  reg  [3:0]  wb_sel_i = 4'hF;
  reg  [31:0] wb_dat_i = 32'h0000_0000;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire [1:0]  timer_output_pin, overflow_irq, match_a_irq, match_b_irq;
  integer     miscompares = 0, n_checks = 0, seed = 5749, k, e;
  integer     gap = 0, guard = 0;
  reg         last_pin = 1'b0;
  reg  [7:0]  lo, hi;
  reg  [31:0] exp_q[$];
  integer     gap_q[$];
  cct_timer_pair dut (
    .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .low_power_return(low_power_return),
    .timer_output_pin(timer_output_pin), .overflow_irq(overflow_irq),
    .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
  initial forever #10 clk_sys = ~clk_sys;
  task check(input string nm, input [31:0] seen, input [31:0] want);
    n_checks = n_checks + 1;
    if (seen !== want) begin
      miscompares = miscompares + 1;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task close_out;
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one classic cycle, held until ack; a read notes its data first
  task bus(input we, input [5:0] a, input [31:0] d);
    if (!we) exp_q.push_back(d);
    guard = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && guard <= 3000) @(posedge clk_sys);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  // oldest note against each read and each pin edge; watchdog too
  always @(posedge clk_sys) begin
    gap = gap + 1;
    guard = guard + 1;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check("read data", wb_dat_o, exp_q.pop_front());
    if (timer_output_pin[0] !== last_pin) begin
      e = (gap_q.size() > 0) ? gap_q.pop_front() : -1;
      if (e >= 0) check("toggle gap", gap, e);
      gap = 0;
      last_pin = timer_output_pin[0];
    end
    if (guard > 3000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    // reset values; writes refused while stopped or unkeyed
    bus(0, 6'h24, 32'h0000_00FF);
    bus(0, 6'h3C, 32'h0000_0000);
    bus(1, 6'h00, 32'h0000_0012);
    bus(1, 6'h34, 32'h0000_0000);
    bus(0, 6'h00, 32'h0000_0000);
    bus(0, 6'h38, 32'h0000_0008);
    // keyed release, then a random 16-bit period with upper byte held to 1 or 2
    bus(1, 6'h30, 32'h0000_A502);
    bus(1, 6'h34, 32'h0000_0000);
    bus(1, 6'h30, 32'h0000_A500);
    k = $random(seed);
    hi = {7'h00, k[0]} + 8'h01;
    lo = k[15:8];
    bus(1, 6'h20, {24'h00_0000, hi});
    bus(1, 6'h24, {24'h00_0000, lo});
    bus(1, 6'h10, 32'h0000_0048);
    bus(1, 6'h14, 32'h0000_0020);
    bus(1, 6'h18, 32'h0000_0003);
    bus(1, 6'h08, 32'h0000_0018);
    bus(1, 6'h0C, 32'h0000_0008);
    // first edge only starts the count; then two full periods
    gap_q.push_back(-1);
    gap_q.push_back({hi, lo} + 1);
    gap_q.push_back({hi, lo} + 1);
    guard = 0;
    while (gap_q.size() > 0 && guard <= 3000) @(posedge clk_sys);
    // stop the lower clock, load both counts, see them hold
    bus(1, 6'h0C, 32'h0000_0000);
    // upper count frozen with the lower clock stopped, so loads stand
    bus(1, 6'h00, 32'h0000_0012);
    bus(0, 6'h00, 32'h0000_0012);
    bus(1, 6'h00, 32'h0000_0000);
    bus(1, 6'h04, {24'h00_0000, lo});
    repeat (10) @(posedge clk_sys);
    bus(0, 6'h04, {24'h00_0000, lo});
    bus(0, 6'h00, 32'h0000_0000);
    // return from low power brings the timer registers back
    low_power_return <= 1'b1;
    @(posedge clk_sys);
    low_power_return <= 1'b0;
    bus(0, 6'h20, 32'h0000_00FF);
    bus(0, 6'h08, 32'h0000_0000);
    bus(0, 6'h04, 32'h0000_0000);
    bus(0, 6'h38, 32'h0000_0000);
    close_out;
  end
endmodule
